// >>> abr_pkg.sv
// Purpose: Shared constants and types for the acquisition busy and reset control
// Assumes: 25 MHz system clock, 32-bit AHB-Lite register bus
// Notes:   Offsets are byte addresses; all registers are one aligned word
package abr_pkg;

  // Register byte offsets
  localparam logic [7:0] ABR_OFS_STATUS1 = 8'h00;
  localparam logic [7:0] ABR_OFS_CTRL1   = 8'h04;
  localparam logic [7:0] ABR_OFS_SET1    = 8'h08;
  localparam logic [7:0] ABR_OFS_CLR1    = 8'h0C;
  localparam logic [7:0] ABR_OFS_SET2    = 8'h10;
  localparam logic [7:0] ABR_OFS_CLR2    = 8'h14;
  localparam logic [7:0] ABR_OFS_SINGLE  = 8'h18;
  localparam logic [7:0] ABR_OFS_ABWIN   = 8'h1C;
  localparam logic [7:0] ABR_OFS_EVCNT   = 8'h20;
  localparam logic [7:0] ABR_OFS_PTRS    = 8'h24;

  // Field positions
  localparam int ABR_ST_DP_LOCAL    = 0;
  localparam int ABR_ST_DP_CHAIN    = 1;
  localparam int ABR_ST_BUSY        = 2;
  localparam int ABR_ST_CHAIN_BUSY  = 3;
  localparam int ABR_ST_FULL        = 4;
  localparam int ABR_CT_PANEL_SCOPE = 4;
  localparam int ABR_S1_SOFT_HOLD   = 7;
  localparam int ABR_S2_MEM_TEST    = 0;
  localparam int ABR_S2_DATA_CLR    = 2;
  localparam int ABR_PT_WR_LSB      = 8;

  // Values after reset
  localparam logic [7:0] ABR_ABWIN_RST  = 8'h10;
  localparam logic [4:0] ABR_PTR_RST    = 5'h00;
  localparam logic [23:0] ABR_EVCNT_RST = 24'h000000;

  // Timing
  localparam int ABR_CLK_PERIOD_NS = 40;
  localparam int ABR_CLR_TIME_NS   = 600;
  localparam int ABR_CFG_TIME_NS   = 1000;
  localparam logic [4:0] ABR_CLR_CYCLES =
    5'((ABR_CLR_TIME_NS + ABR_CLK_PERIOD_NS - 1) / ABR_CLK_PERIOD_NS);
  localparam logic [4:0] ABR_CFG_CYCLES =
    5'((ABR_CFG_TIME_NS + ABR_CLK_PERIOD_NS - 1) / ABR_CLK_PERIOD_NS);

  // Synchronised input indices
  localparam int ABR_IN_COMMON  = 0;
  localparam int ABR_IN_SINGLE  = 1;
  localparam int ABR_IN_ABORT   = 2;
  localparam int ABR_IN_PANEL   = 3;
  localparam int ABR_IN_INHIBIT = 4;
  localparam int ABR_IN_JUMPER  = 5;
  localparam int ABR_IN_CBUSY   = 6;
  localparam int ABR_IN_CDP     = 7;
  localparam int ABR_IN_COUNT   = 8;

  typedef enum logic [1:0] {
    ABR_IDLE    = 2'b00,
    ABR_CONVERT = 2'b01,
    ABR_RECOVER = 2'b10
  } abr_state_t;

endpackage

// >>> abr_edge_if.sv
`timescale 1ns/10ps
// Purpose: Carries a synchronised level and its rising edge between modules
// Assumes: Single clock domain on the consuming side
// Notes:   Source is the synchroniser, sink is the control core
interface abr_edge_if;
  logic level;
  logic rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface

// >>> abr_sync_edge.sv
`timescale 1ns/10ps
// Purpose: Two-stage synchroniser with rising-edge detect for one pin
// Assumes: Pin is asynchronous to hclk
// Notes:   First stage feeds only the second stage
module abr_sync_edge (
  input  wire logic  hclk,
  input  wire logic  hresetn,
  input  wire logic  pin,
  abr_edge_if.src    sig
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } abr_sync_t;

  abr_sync_t st;
  abr_sync_t next_st;

  always_comb begin
    next_st      = st;
    next_st.meta = pin;
    next_st.sync = st.meta;
    next_st.prev = st.sync;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sig.level = st.sync;
  assign sig.rise  = st.sync & ~st.prev;
endmodule

// >>> abr_acq_ctrl.sv
`timescale 1ns/10ps
// Purpose: Busy generation, data/soft/hard reset and abort window control
// Assumes: hclk 25 MHz; hresetn is power-on or host bus system reset
// Notes:   Reads take one wait state; writes complete with no wait
// Operation
// - Busy while converting, recovering, buffer full or memory test active.
// - Busy drives panel busy output and status busy flags.
// - Busy rises after accepted timing edge, falls when conversion completes.
// - Further timing pulses ignored while busy.
// - Jumper selects halting on chain busy or on own busy.
// - Busy also shown during configuration interval after power-on.
// - Data reset empties buffer, clears pointers, counter, ramp stages.
// - Data clear bit set via set2 holds data reset until cleared.
// - Panel reset gives data or soft reset per panel scope bit.
// - Soft reset does data reset plus restores soft-reset registers.
// - Soft hold bit via set1 holds soft reset until clear1 write.
// - Write to single reset register gives soft reset for that access.
// - Hard reset at power-on and host system reset restores everything.
// - Abort inside programmed window cancels conversion, else ignored.
// - Accepted abort starts clear cycle; timing accepted 600 ns later.
// - Data-present line and flag follow buffer; chain level mirrored.
// - Busy lines drive OR and NAND; chain busy level reported.
// - No conversion started while inhibit is active.
// - Common and single-ended timing inputs are ORed together.
// - Buffer full when pointers equal and last increment was write.
// - Timing pulse accepted only without inhibit, abort or busy.
module abr_acq_ctrl
  import abr_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        common_timing_input,
  input  wire logic        single_ended_timing_input,
  input  wire logic        abort_conversion_input,
  input  wire logic        panel_reset_input,
  input  wire logic        inhibit_input,
  input  wire logic        stop_scope_jumper,
  input  wire logic        chain_busy_input,
  input  wire logic        chain_data_present_input,
  input  wire logic        conv_done,
  input  wire logic        event_store,
  input  wire logic        read_event_incr,
  output logic             busy_pos,
  output logic             busy_neg,
  output logic             data_present_pos,
  output logic             data_present_neg,
  output logic             conv_start,
  output logic             conv_abort,
  output logic             ramp_converter_reset,
  output logic             event_buffer_clear
);

  typedef struct packed {
    abr_state_t  state;
    logic [7:0]  win_cnt;
    logic [4:0]  rec_cnt;
    logic [4:0]  cfg_cnt;
    logic [4:0]  wr_ptr;
    logic [4:0]  rd_ptr;
    logic        last_wr;
    logic [23:0] evt_cnt;
    logic        panel_scope;
    logic        soft_hold;
    logic        data_clr;
    logic        mem_test;
    logic [7:0]  abort_win;
    logic        ph_wr;
    logic        ph_rd;
    logic [7:0]  ph_addr;
    logic [31:0] rdata;
    logic        busy;
    logic        dp;
    logic        start;
    logic        abort;
    logic        ramp_rst;
    logic        buf_clr;
  } abr_core_t;

  abr_core_t st;
  abr_core_t next_st;

  logic [ABR_IN_COUNT-1:0] raw;
  logic [ABR_IN_COUNT-1:0] lvl;
  logic [ABR_IN_COUNT-1:0] rise;

  assign raw[ABR_IN_COMMON]  = common_timing_input;
  assign raw[ABR_IN_SINGLE]  = single_ended_timing_input;
  assign raw[ABR_IN_ABORT]   = abort_conversion_input;
  assign raw[ABR_IN_PANEL]   = panel_reset_input;
  assign raw[ABR_IN_INHIBIT] = inhibit_input;
  assign raw[ABR_IN_JUMPER]  = stop_scope_jumper;
  assign raw[ABR_IN_CBUSY]   = chain_busy_input;
  assign raw[ABR_IN_CDP]     = chain_data_present_input;

  genvar gi;
  generate
    for (gi = 0; gi < ABR_IN_COUNT; gi++) begin : g_sync
      abr_edge_if u_if ();
      abr_sync_edge u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (raw[gi]),
        .sig     (u_if)
      );
      assign lvl[gi]  = u_if.level;
      assign rise[gi] = u_if.rise;
    end
  endgenerate

  logic       timing_rise;
  logic       halt;
  logic       full;
  logic       empty;
  logic       single_pulse;
  logic       data_rst;
  logic       soft_rst;
  logic       any_rst;
  logic       accept;
  logic       abort_hit;
  logic       addr_phase;
  logic [7:0] waddr;

  always_comb begin
    timing_rise  = rise[ABR_IN_COMMON] | rise[ABR_IN_SINGLE];
    full         = (st.rd_ptr == st.wr_ptr) & st.last_wr;
    empty        = (st.rd_ptr == st.wr_ptr) & ~st.last_wr;
    halt         = st.busy | (lvl[ABR_IN_JUMPER] & lvl[ABR_IN_CBUSY]);
    // Reset for the write data phase
    single_pulse = st.ph_wr & (st.ph_addr == ABR_OFS_SINGLE);
    data_rst     = st.data_clr | (rise[ABR_IN_PANEL] & ~st.panel_scope);
    soft_rst     = st.soft_hold | single_pulse |
                   (rise[ABR_IN_PANEL] & st.panel_scope);
    any_rst      = data_rst | soft_rst;
    accept       = timing_rise & ~lvl[ABR_IN_INHIBIT] & ~lvl[ABR_IN_ABORT] &
                   ~halt & ~any_rst;
    abort_hit    = rise[ABR_IN_ABORT] & (st.state == ABR_CONVERT) &
                   (st.win_cnt != 8'h00);
    addr_phase   = hsel & hready & htrans[1];
    waddr        = {haddr[7:2], 2'b00};
  end

  function automatic logic [31:0] abr_read(input abr_core_t s, input logic [7:0] a,
                                           input logic f, input logic e,
                                           input logic cdp, input logic cb);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      ABR_OFS_STATUS1: begin
        v[ABR_ST_DP_LOCAL]   = ~e;
        v[ABR_ST_DP_CHAIN]   = cdp;
        v[ABR_ST_BUSY]       = s.busy;
        v[ABR_ST_CHAIN_BUSY] = cb;
        v[ABR_ST_FULL]       = f;
      end
      ABR_OFS_CTRL1: v[ABR_CT_PANEL_SCOPE] = s.panel_scope;
      ABR_OFS_SET1:  v[ABR_S1_SOFT_HOLD]   = s.soft_hold;
      ABR_OFS_SET2: begin
        v[ABR_S2_MEM_TEST] = s.mem_test;
        v[ABR_S2_DATA_CLR] = s.data_clr;
      end
      ABR_OFS_ABWIN: v[7:0]  = s.abort_win;
      ABR_OFS_EVCNT: v[23:0] = s.evt_cnt;
      ABR_OFS_PTRS: begin
        v[4:0]                          = s.rd_ptr;
        v[ABR_PT_WR_LSB+4:ABR_PT_WR_LSB] = s.wr_ptr;
      end
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  always_comb begin
    next_st       = st;
    next_st.start = 1'b0;
    next_st.abort = 1'b0;

    // Bus phase tracking
    if (st.ph_rd) begin
      next_st.rdata = abr_read(st, st.ph_addr, full, empty,
                               lvl[ABR_IN_CDP], lvl[ABR_IN_CBUSY]);
      next_st.ph_rd = 1'b0;
    end else if (hready) begin
      next_st.ph_wr   = addr_phase & hwrite;
      next_st.ph_rd   = addr_phase & ~hwrite;
      next_st.ph_addr = waddr;
    end

    // Register writes in the data phase
    if (st.ph_wr) begin
      unique case (st.ph_addr)
        ABR_OFS_CTRL1: next_st.panel_scope = hwdata[ABR_CT_PANEL_SCOPE];
        ABR_OFS_SET1: begin
          if (hwdata[ABR_S1_SOFT_HOLD]) begin
            next_st.soft_hold = 1'b1;
          end
        end
        ABR_OFS_CLR1: begin
          if (hwdata[ABR_S1_SOFT_HOLD]) begin
            next_st.soft_hold = 1'b0;
          end
        end
        ABR_OFS_SET2: begin
          if (hwdata[ABR_S2_DATA_CLR]) begin
            next_st.data_clr = 1'b1;
          end
          if (hwdata[ABR_S2_MEM_TEST]) begin
            next_st.mem_test = 1'b1;
          end
        end
        ABR_OFS_CLR2: begin
          if (hwdata[ABR_S2_DATA_CLR]) begin
            next_st.data_clr = 1'b0;
          end
          if (hwdata[ABR_S2_MEM_TEST]) begin
            next_st.mem_test = 1'b0;
          end
        end
        ABR_OFS_ABWIN: next_st.abort_win = hwdata[7:0];
        default: ;
      endcase
    end

    // Configuration interval count-down
    if (st.cfg_cnt != 5'h00) begin
      next_st.cfg_cnt = st.cfg_cnt - 5'h01;
    end

    // Event buffer pointers
    if (read_event_incr && !empty) begin
      next_st.rd_ptr  = st.rd_ptr + 5'h01;
      next_st.last_wr = 1'b0;
    end

    // Conversion sequence
    unique case (st.state)
      ABR_IDLE: begin
        if (accept) begin
          next_st.state   = ABR_CONVERT;
          next_st.win_cnt = st.abort_win;
          next_st.start   = 1'b1;
          next_st.evt_cnt = st.evt_cnt + 24'h000001;
        end
      end
      ABR_CONVERT: begin
        if (st.win_cnt != 8'h00) begin
          next_st.win_cnt = st.win_cnt - 8'h01;
        end
        if (abort_hit) begin
          next_st.state   = ABR_RECOVER;
          next_st.rec_cnt = ABR_CLR_CYCLES;
          next_st.abort   = 1'b1;
        end else if (conv_done) begin
          next_st.state = ABR_IDLE;
          if (event_store && !full) begin
            next_st.wr_ptr  = st.wr_ptr + 5'h01;
            next_st.last_wr = 1'b1;
          end
        end
      end
      ABR_RECOVER: begin
        if (st.rec_cnt <= 5'h01) begin
          next_st.state = ABR_IDLE;
        end else begin
          next_st.rec_cnt = st.rec_cnt - 5'h01;
        end
      end
      default: next_st.state = ABR_IDLE;
    endcase

    // Any reset aborts and holds recovery
    if (any_rst) begin
      next_st.abort   = (st.state == ABR_CONVERT);
      next_st.state   = ABR_RECOVER;
      next_st.rec_cnt = ABR_CLR_CYCLES;
      next_st.wr_ptr  = ABR_PTR_RST;
      next_st.rd_ptr  = ABR_PTR_RST;
      next_st.last_wr = 1'b0;
      next_st.evt_cnt = ABR_EVCNT_RST;
    end
    if (soft_rst) begin
      next_st.abort_win = ABR_ABWIN_RST;
      next_st.mem_test  = 1'b0;
      next_st.data_clr  = 1'b0;
    end

    next_st.busy     = (next_st.state != ABR_IDLE) | next_st.mem_test |
                       (next_st.cfg_cnt != 5'h00) |
                       ((next_st.rd_ptr == next_st.wr_ptr) & next_st.last_wr);
    next_st.dp       = ~((next_st.rd_ptr == next_st.wr_ptr) & ~next_st.last_wr);
    next_st.ramp_rst = (next_st.state == ABR_RECOVER);
    next_st.buf_clr  = any_rst;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st           <= '0;
      st.state     <= ABR_IDLE;
      st.cfg_cnt   <= ABR_CFG_CYCLES;
      st.abort_win <= ABR_ABWIN_RST;
      st.busy      <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign hreadyout            = ~st.ph_rd;
  assign hresp                = 1'b0;
  assign hrdata               = st.rdata;
  assign busy_pos             = st.busy;
  assign busy_neg             = ~st.busy;
  assign data_present_pos     = st.dp;
  assign data_present_neg     = ~st.dp;
  // Start pulse already gated by inhibit
  assign conv_start           = st.start;
  assign conv_abort           = st.abort;
  assign ramp_converter_reset = st.ramp_rst;
  assign event_buffer_clear   = st.buf_clr;

endmodule

// >>> abr_acq_monitor.sv
`timescale 1ns/10ps
// Purpose: Port checks on busy, reset and abort control
// Assumes: One hclk domain, hresetn async active low
// Notes:   Bound to abr_acq_ctrl
module abr_acq_monitor (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       inhibit_input,
  input wire logic       conv_start,
  input wire logic       conv_abort,
  input wire logic       busy_pos,
  input wire logic       busy_neg,
  input wire logic       data_present_pos,
  input wire logic       data_present_neg,
  input wire logic       ramp_converter_reset
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd_req; hsel && hready && htrans[1] && !hwrite; endsequence
  sequence s_rd_wait; !hreadyout ##1 hreadyout; endsequence
  sequence s_recover; busy_pos[*8]; endsequence
  property p_rd_wait; s_rd_req |=> s_rd_wait; endproperty
  property p_start_busy; conv_start |-> busy_pos; endproperty
  property p_start_free; conv_start |-> !$past(busy_pos); endproperty
  property p_start_pulse; conv_start |=> !conv_start; endproperty
  property p_busy_inv; busy_neg == !busy_pos; endproperty
  property p_dp_inv; data_present_neg == !data_present_pos; endproperty
  property p_inhibit; inhibit_input[*8] |-> !conv_start; endproperty
  property p_abort_rec; conv_abort |=> s_recover; endproperty
  property p_ramp_busy; ramp_converter_reset |-> ##[0:1] busy_pos; endproperty
  property p_start_clean; conv_start |-> !ramp_converter_reset; endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read wait state wrong");
  a_start_busy: assert property (p_start_busy)
    else $error("start without busy");
  a_start_free: assert property (p_start_free)
    else $error("start while busy");
  a_start_pulse: assert property (p_start_pulse)
    else $error("start longer than one cycle");
  a_busy_inv: assert property (p_busy_inv)
    else $error("busy pair not complementary");
  a_dp_inv: assert property (p_dp_inv)
    else $error("data present pair not complementary");
  a_inhibit: assert property (p_inhibit)
    else $error("start under inhibit");
  a_abort_rec: assert property (p_abort_rec)
    else $error("busy dropped in clear cycle");
  a_ramp_busy: assert property (p_ramp_busy)
    else $error("ramp reset without busy");
  a_start_clean: assert property (p_start_clean)
    else $error("start during reset");
endmodule
bind abr_acq_ctrl abr_acq_monitor i_abr_acq_monitor (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .inhibit_input(inhibit_input),
  .conv_start(conv_start), .conv_abort(conv_abort), .busy_pos(busy_pos),
  .busy_neg(busy_neg), .data_present_pos(data_present_pos),
  .data_present_neg(data_present_neg), .ramp_converter_reset(ramp_converter_reset)
);

// >>> abr_far_model.sv
`timescale 1ns/10ps
// Purpose: Converter and neighbour boards facing the control block
// Assumes: Conversion ends conv_len cycles after conv_start
// Notes:   event_store means something only with conv_done
module abr_far_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [7:0] conv_len,
  input  wire logic       conv_start,
  input  wire logic       conv_abort,
  input  wire logic       busy_pos,
  input  wire logic       data_present_pos,
  input  wire logic       oth_busy,
  input  wire logic       oth_dp,
  output logic            conv_done,
  output logic            event_store,
  output logic            chain_busy_input,
  output logic            chain_data_present_input
);
  logic [7:0] cnt;
  logic       run;
  logic       pat;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run <= 1'h0;
      cnt <= 8'h00;
      pat <= 1'h0;
      conv_done <= 1'h0;
    end else begin
      pat <= ~pat;
      conv_done <= 1'h0;
      if (conv_abort) begin
        run <= 1'h0;
      end else if (conv_start) begin
        run <= 1'h1;
        cnt <= conv_len;
      end else if (run) begin
        cnt <= cnt - 8'h01;
        if (cnt == 8'h01) begin
          run <= 1'h0;
          conv_done <= 1'h1;
        end
      end
    end
  end
  assign event_store = conv_done ? 1'h1 : pat;
  assign chain_busy_input = busy_pos | oth_busy;
  assign chain_data_present_input = data_present_pos | oth_dp;
endmodule

// >>> tb.sv
`timescale 1ns/10ps
// Purpose: Self-checking bench for abr_acq_ctrl
// Assumes: Read data checked against queued notes
// Notes:   Far side modelled by abr_far_model
module tb;
  import abr_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rd_dp, read_event_incr;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  pins;
  logic [7:0]  conv_len, v;
  logic        inhibit_input, stop_scope_jumper, chain_busy_input, chain_data_present_input;
  logic        conv_done, event_store, busy_pos, busy_neg, conv_start, conv_abort;
  logic        data_present_pos, data_present_neg, oth_busy, oth_dp, buf_clr;
  logic [31:0] exp_q[$];
  int          mismatches, num_checks, n_start, n_abort, cyc, n_clr, n_clr0;
  assign hready = hreadyout;
  abr_acq_ctrl i_abr_acq_ctrl (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .common_timing_input(pins[0]),
    .single_ended_timing_input(pins[1]), .abort_conversion_input(pins[2]),
    .panel_reset_input(pins[3]), .inhibit_input, .stop_scope_jumper, .chain_busy_input,
    .chain_data_present_input, .conv_done, .event_store, .read_event_incr, .busy_pos,
    .busy_neg, .data_present_pos, .data_present_neg, .conv_start, .conv_abort,
    .ramp_converter_reset(), .event_buffer_clear(buf_clr)
  );
  abr_far_model i_abr_far_model (
    .hclk, .hresetn, .conv_len, .conv_start, .conv_abort, .busy_pos, .data_present_pos,
    .oth_busy, .oth_dp, .conv_done, .event_store, .chain_busy_input,
    .chain_data_present_input
  );
  initial begin
    hclk = 1'h0;
    forever #20 hclk = ~hclk;
  end
  task stop_test;
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task chk_rd;
    logic [31:0] e;
    e = 'x;
    if (exp_q.size() > 0) e = exp_q.pop_front();
    chk(hrdata, e, "read");
    chk({31'h0, hresp}, 32'h0, "resp");
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      stop_test;
    end
    if (hsel && hready && htrans[1] && !hwrite) rd_dp <= 1'h1;
    else if (hready) rd_dp <= 1'h0;
    if (conv_start === 1'h1) n_start <= n_start + 1;
    if (conv_abort === 1'h1) n_abort <= n_abort + 1;
    if (buf_clr === 1'h1) n_clr <= n_clr + 1;
  end
  always @(negedge hclk) if (rd_dp && hreadyout === 1'h1) chk_rd;
  task wait_rdy;
    logic r;
    do begin
      @(negedge hclk);
      r = hreadyout;
      @(posedge hclk);
    end while (r !== 1'h1);
  endtask
  // Write d, or read and note d as expected
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy;
    htrans <= 2'h0;
    if (w) hwdata <= d;
    else exp_q.push_back(d);
    wait_rdy;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'h1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] d);
    ahb(1'h0, a, d);
  endtask
  task pulse(input int k);
    pins[k] <= 1'h1;
    repeat (3) @(posedge hclk);
    pins[k] <= 1'h0;
    repeat (5) @(posedge hclk);
  endtask
  task wait_idle;
    logic ok;
    ok = 1'h0;
    for (int i = 0; i < 300; i++) begin
      @(negedge hclk);
      if (busy_pos === 1'h0) begin
        ok = 1'h1;
        i = 300;
      end
      @(posedge hclk);
    end
    chk(ok, 1'h1, "idle");
  endtask
  initial begin
    {hresetn, hwrite, htrans, haddr, hwdata, pins} = '0;
    {inhibit_input, stop_scope_jumper, read_event_incr, oth_busy, oth_dp} = '0;
    hsel = 1'h1;
    hsize = 3'h2;
    conv_len = 8'h28;
    void'($urandom(43082));
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    @(negedge hclk);
    chk(busy_pos, 1'h1, "config busy");
    @(posedge hclk);
    rd(ABR_OFS_ABWIN, 32'h10);
    rd(ABR_OFS_SET2, 32'h0);
    wait_idle;
    $display("Test reset done");
    pulse(0);
    pulse(0);
    wait_idle;
    chk(n_start, 1, "start");
    rd(ABR_OFS_EVCNT, 32'h1);
    rd(ABR_OFS_STATUS1, 32'h3);
    pulse(1);
    wait_idle;
    rd(ABR_OFS_PTRS, 32'h200);
    read_event_incr <= 1'h1;
    @(posedge hclk);
    read_event_incr <= 1'h0;
    inhibit_input <= 1'h1;
    pulse(0);
    inhibit_input <= 1'h0;
    stop_scope_jumper <= 1'h1;
    oth_busy <= 1'h1;
    pulse(0);
    rd(ABR_OFS_STATUS1, 32'hB);
    stop_scope_jumper <= 1'h0;
    chk(n_start, 2, "refused");
    $display("Test busy done");
    pulse(0);
    pulse(2);
    pulse(0);
    wait_idle;
    chk(n_abort, 1, "abort in");
    chk(n_start, 3, "start near abort");
    oth_busy <= 1'h0;
    rd(ABR_OFS_PTRS, 32'h201);
    wr(ABR_OFS_ABWIN, 32'h2);
    pulse(0);
    pulse(2);
    wait_idle;
    chk(n_abort, 1, "abort out");
    rd(ABR_OFS_PTRS, 32'h301);
    $display("Test abort done");
    wr(ABR_OFS_SET2, 32'h4);
    rd(ABR_OFS_EVCNT, 32'h0);
    wr(ABR_OFS_CLR2, 32'h4);
    wait_idle;
    rd(ABR_OFS_ABWIN, 32'h2);
    pulse(0);
    wait_idle;
    pulse(3);
    wait_idle;
    rd(ABR_OFS_PTRS, 32'h0);
    rd(ABR_OFS_ABWIN, 32'h2);
    wr(ABR_OFS_CTRL1, 32'h10);
    pulse(3);
    wait_idle;
    rd(ABR_OFS_ABWIN, 32'h10);
    rd(ABR_OFS_CTRL1, 32'h10);
    wr(ABR_OFS_ABWIN, 32'h7);
    n_clr0 = n_clr;
    wr(ABR_OFS_SINGLE, 32'h0);
    wait_idle;
    chk(n_clr - n_clr0, 1, "single reset length");
    rd(ABR_OFS_ABWIN, 32'h10);
    wr(ABR_OFS_ABWIN, 32'h7);
    wr(ABR_OFS_SET1, 32'h80);
    rd(ABR_OFS_ABWIN, 32'h10);
    wr(ABR_OFS_CLR1, 32'h80);
    wait_idle;
    rd(ABR_OFS_SET1, 32'h0);
    wr(ABR_OFS_SET2, 32'h1);
    repeat (3) @(posedge hclk);
    rd(ABR_OFS_STATUS1, 32'hC);
    wr(ABR_OFS_CLR2, 32'h1);
    wait_idle;
    rd(8'h3C, 32'h0);
    $display("Test resets done");
    repeat (4) begin
      v = 8'($urandom_range(255, 0));
      wr(ABR_OFS_ABWIN, {24'h000000, v});
      rd(ABR_OFS_ABWIN, {24'h000000, v});
    end
    pulse(0);
    hresetn <= 1'h0;
    @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rd(ABR_OFS_ABWIN, 32'h10);
    wait_idle;
    $display("Test random done");
    repeat (4) @(posedge hclk);
    stop_test;
  end
endmodule
